// ### fes_top.sv
// flash erase command sequencer with small internal array model
// Overview of operation
// - aa@555, 55@2aa, 80@555, aa@555, 55@2aa, 30@sector starts sector erase
// - same five writes then 10@555 starts whole-chip erase
// - device preprograms targets to zero and verifies before erasing
// - erased locations read back as all ones
// - all erase control and timing generated internally
// - acceptance window of at least minimum time from final strobe rise
// - further 30h writes during window queue more sectors, any order
// - command other than 30h or suspend in window abandons erase, bank back to read
// - erase_timer_flag high while preprogram or erase runs after the window; low in window and while suspended
// - on completion bank returns to read, latched sectors released
// - non-erasing banks keep serving array reads
// - reads of erasing bank return progress status bits
// - once erasing, only suspend is acted upon
// - hardware reset stops erase at once; host reissues sequence
// - chip erase ignores every command
// - suspend in window ends window and suspends erase
// - suspend during chip erase has no effect
`timescale 1ns/1ps
`include "fes_map.svh"
module fes_top
    import fes_pkg::*;
#(
    parameter int WINDOW_CYC = `FES_WINDOW_CYC
)
(
    input  wire logic                     clock,
    input  wire logic                     rst_n,
    input  wire logic                     write_strobe_n,
    input  wire logic                     read_strobe_n,
    input  wire logic [`FES_ADDR_W-1:0]   addr,
    input  wire logic [`FES_DATA_W-1:0]   wdata,
    output logic      [`FES_DATA_W-1:0]   rdata,
    output logic                          rdata_valid,
    output logic                          erase_busy,
    output logic                          erase_timer_flag,
    output logic                          erase_suspended
);
    localparam int NS = `FES_SECTORS;
    localparam int SW = $clog2(NS);
    localparam int BW = $clog2(`FES_BANKS);
    localparam int AW = `FES_ADDR_W;
    localparam int DW = `FES_DATA_W;

    // every pin is asynchronous; strobes idle high, bus lines low
    localparam int PW = AW + DW + 2;
    logic [PW-1:0] pins;
    logic [PW-1:0] pins_s;
    assign pins = {wdata, addr, read_strobe_n, write_strobe_n};
    wire logic          we_n_s = pins_s[0];
    wire logic          re_n_s = pins_s[1];
    wire logic [AW-1:0] addr_s = pins_s[2 +: AW];
    wire logic [DW-1:0] data_s = pins_s[AW+2 +: DW];
    genvar gi;
    generate
        for (gi = 0; gi < PW; gi++)
        begin : g_pin
            fes_sync #(.INIT(gi < 2)) u_s
            (
                .clock (clock),
                .rst_n (rst_n),
                .pin   (pins[gi]),
                .level (pins_s[gi])
            );
        end
    endgenerate

    // strobe edges; bus is stable while strobe is low
    logic we_d_reg;
    logic re_d_reg;
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            we_d_reg <= 1'b1;
            re_d_reg <= 1'b1;
        end
        else
        begin
            we_d_reg <= we_n_s;
            re_d_reg <= re_n_s;
        end
    end
    wire logic          wr_evt = we_n_s & ~we_d_reg;
    wire logic          rd_evt = ~re_n_s & re_d_reg;
    wire logic [SW-1:0] w_sect = addr_s[`FES_SECT_LSB +: SW];
    wire logic [BW-1:0] w_bank = addr_s[`FES_BANK_LSB +: BW];
    wire logic          is_aa1 = addr_s == `FES_UNLOCK_A1
                              && data_s == `FES_DAT_AA;
    wire logic          is_552 = addr_s == `FES_UNLOCK_A2
                              && data_s == `FES_DAT_55;

    fes_seq_t      seq_reg;
    fes_op_t       op_reg;
    logic          chip_reg;
    logic [NS-1:0] sel_reg;
    logic [NS-1:0] zero_reg;
    logic [NS-1:0] ones_reg;
    logic [BW-1:0] bank_reg;
    logic [SW-1:0] step_reg;
    logic          tog_reg;
    logic          tog2_reg;
    wire logic cmd_ok     = wr_evt && seq_reg == FES_SEQ_U5;
    wire logic start_sect = cmd_ok && op_reg == FES_OP_READ
                         && data_s == `FES_DAT_SECTOR;
    wire logic start_chip = cmd_ok && op_reg == FES_OP_READ
                         && addr_s == `FES_UNLOCK_A1
                         && data_s == `FES_DAT_CHIP;

    // command sequence; busy states route writes to op logic instead
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            seq_reg <= FES_SEQ_IDLE;
        else if (wr_evt && (op_reg == FES_OP_READ))
        begin
            case (seq_reg)
                FES_SEQ_IDLE:
                    seq_reg <= is_aa1 ? FES_SEQ_U1 : FES_SEQ_IDLE;
                FES_SEQ_U1:
                    seq_reg <= is_552 ? FES_SEQ_U2 : FES_SEQ_IDLE;
                FES_SEQ_U2:
                    seq_reg <= (addr_s == `FES_UNLOCK_A1
                             && data_s == `FES_DAT_SETUP)
                             ? FES_SEQ_SETUP : FES_SEQ_IDLE;
                FES_SEQ_SETUP:
                    seq_reg <= is_aa1 ? FES_SEQ_U4 : FES_SEQ_IDLE;
                FES_SEQ_U4:
                    seq_reg <= is_552 ? FES_SEQ_U5 : FES_SEQ_IDLE;
                default:
                    seq_reg <= FES_SEQ_IDLE;
            endcase
        end
    end

    // window timer restarts on each accepted sector write
    logic win_load;
    logic win_stop;
    logic win_done;
    logic add_sect;
    logic suspend_cmd;
    assign add_sect    = wr_evt && op_reg == FES_OP_WINDOW
                      && data_s == `FES_DAT_SECTOR;
    assign suspend_cmd = wr_evt && data_s == `FES_DAT_SUSPEND
                      && !chip_reg;
    assign win_load = start_sect || add_sect;
    assign win_stop = op_reg != FES_OP_WINDOW && !start_sect;
    fes_timer #(.WIDTH(32)) u_win
    (
        .clock   (clock),
        .rst_n   (rst_n),
        .load    (win_load),
        .stop    (win_stop),
        .count   (32'(WINDOW_CYC)),
        .running (),
        .done    (win_done)
    );

    // per-sector step timer paces internal preprogram and erase
    logic step_load;
    logic step_run;
    logic step_done;
    fes_timer #(.WIDTH(8)) u_step
    (
        .clock   (clock),
        .rst_n   (rst_n),
        .load    (step_load),
        .stop    (1'b0),
        .count   (8'(`FES_STEP_CYC)),
        .running (step_run),
        .done    (step_done)
    );

    wire logic step_hit = sel_reg[step_reg];
    assign step_load = (op_reg == FES_OP_PREPROG || op_reg == FES_OP_ERASE)
                    && !step_run && !step_done;

    // operation state; reset aborts mid-erase
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            op_reg   <= FES_OP_READ;
            chip_reg <= 1'b0;
            sel_reg  <= '0;
            bank_reg <= '0;
            step_reg <= '0;
        end
        else
        begin
            case (op_reg)
                FES_OP_READ:
                begin
                    if (start_sect)
                    begin
                        op_reg  <= FES_OP_WINDOW;
                        sel_reg <= NS'(1) << w_sect;
                        bank_reg <= w_bank;
                    end
                    else if (start_chip)
                    begin
                        op_reg   <= FES_OP_PREPROG;
                        chip_reg <= 1'b1;
                        sel_reg  <= '1;
                        step_reg <= '0;
                    end
                end
                FES_OP_WINDOW:
                begin
                    if (add_sect)
                        sel_reg[w_sect] <= 1'b1;
                    else if (suspend_cmd)
                        op_reg <= FES_OP_SUSP;
                    else if (wr_evt)
                    begin
                        op_reg  <= FES_OP_READ;
                        sel_reg <= '0;
                    end
                    else if (win_done)
                    begin
                        op_reg   <= FES_OP_PREPROG;
                        step_reg <= '0;
                    end
                end
                FES_OP_PREPROG, FES_OP_ERASE:
                begin
                    // other commands fall through unused
                    if (suspend_cmd)
                        op_reg <= FES_OP_SUSP;
                    else if (step_done || (!step_hit && !step_run))
                    begin
                        step_reg <= step_reg + 1'b1;
                        if (step_reg == SW'(NS - 1))
                        begin
                            if (op_reg == FES_OP_ERASE)
                            begin
                                op_reg   <= FES_OP_READ;
                                sel_reg  <= '0;
                                chip_reg <= 1'b0;
                            end
                            else
                                op_reg <= FES_OP_ERASE;
                        end
                    end
                end
                FES_OP_SUSP:
                begin
                    if (wr_evt && data_s == `FES_DAT_RESUME)
                        op_reg <= FES_OP_PREPROG;
                end
                default:
                    op_reg <= FES_OP_READ;
            endcase
        end
    end

    // cell contents model: zeroed then verified, then set to ones
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            zero_reg <= '0;
            ones_reg <= '0;
        end
        else if (step_done && step_hit)
        begin
            if (op_reg == FES_OP_PREPROG)
            begin
                zero_reg[step_reg] <= 1'b1;
                ones_reg[step_reg] <= 1'b0;
            end
            else if (op_reg == FES_OP_ERASE && zero_reg[step_reg])
            begin
                ones_reg[step_reg] <= 1'b1;
                zero_reg[step_reg] <= 1'b0;
            end
        end
    end

    wire logic busy         = op_reg != FES_OP_READ;
    wire logic erasing_bank = busy && (chip_reg || w_bank == bank_reg);
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            tog_reg  <= 1'b0;
            tog2_reg <= 1'b0;
        end
        else if (rd_evt && erasing_bank)
        begin
            if (op_reg != FES_OP_SUSP)
                tog_reg <= ~tog_reg;
            if (sel_reg[w_sect])
                tog2_reg <= ~tog2_reg;
        end
    end

    // read path; unprogrammed cells show a neutral pattern
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            rdata       <= '0;
            rdata_valid <= 1'b0;
        end
        else
        begin
            rdata_valid <= rd_evt;
            if (rd_evt && erasing_bank)
                rdata <= {8'h00, 1'b0, tog_reg, 2'b00,
                          erase_timer_flag, tog2_reg, 2'b00};
            else if (rd_evt)
                rdata <= ones_reg[w_sect] ? `FES_ONES
                       : zero_reg[w_sect] ? 16'h0000
                       : 16'h5a5a;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            erase_busy       <= 1'b0;
            erase_timer_flag <= 1'b0;
            erase_suspended  <= 1'b0;
        end
        else
        begin
            erase_busy       <= busy;
            erase_timer_flag <= op_reg == FES_OP_PREPROG
                             || op_reg == FES_OP_ERASE;
            erase_suspended  <= op_reg == FES_OP_SUSP;
        end
    end
endmodule

// ### fes_map.svh
// register-free constants for the flash erase sequencer
`ifndef FES_MAP_SVH
`define FES_MAP_SVH
`define FES_ADDR_W        12
`define FES_DATA_W        16
`define FES_UNLOCK_A1     12'h555
`define FES_UNLOCK_A2     12'h2aa
`define FES_DAT_AA        16'h00aa
`define FES_DAT_55        16'h0055
`define FES_DAT_SETUP     16'h0080
`define FES_DAT_SECTOR    16'h0030
`define FES_DAT_CHIP      16'h0010
`define FES_DAT_SUSPEND   16'h00b0
`define FES_DAT_RESUME    16'h0030
`define FES_ONES          16'hffff
`define FES_SECTORS       16
`define FES_SECT_LSB      8
`define FES_BANKS         4
`define FES_BANK_LSB      10
`define FES_CLK_NS        100
`define FES_WINDOW_US     50
`define FES_WINDOW_CYC    ((`FES_WINDOW_US * 1000 + `FES_CLK_NS - 1) / `FES_CLK_NS)
`define FES_STEP_CYC      4
`define FES_TOGGLE_CYC    2
`endif

// ### fes_pkg.sv
// types for the flash erase sequencer
package fes_pkg;
    typedef enum logic [2:0]
    {
        FES_SEQ_IDLE  = 3'b000,
        FES_SEQ_U1    = 3'b001,
        FES_SEQ_U2    = 3'b010,
        FES_SEQ_SETUP = 3'b011,
        FES_SEQ_U4    = 3'b100,
        FES_SEQ_U5    = 3'b101
    } fes_seq_t;
    typedef enum logic [2:0]
    {
        FES_OP_READ    = 3'b000,
        FES_OP_WINDOW  = 3'b001,
        FES_OP_PREPROG = 3'b010,
        FES_OP_ERASE   = 3'b011,
        FES_OP_SUSP    = 3'b100
    } fes_op_t;
endpackage

// ### fes_sync.sv
// two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
module fes_sync
#(
    parameter logic INIT = 1'b1
)
(
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic pin,
    output logic      level
);
    logic meta_reg;
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            meta_reg <= INIT;
            level    <= INIT;
        end
        else
        begin
            meta_reg <= pin;
            level    <= meta_reg;
        end
    end
endmodule

// ### fes_timer.sv
// loadable down counter, done pulses when it reaches zero
`timescale 1ns/1ps
module fes_timer
#(
    parameter int WIDTH = 16
)
(
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             load,
    input  wire logic             stop,
    input  wire logic [WIDTH-1:0] count,
    output logic                  running,
    output logic                  done
);
    logic [WIDTH-1:0] cnt_reg;
    always_ff @(posedge clock)
    begin
        if (!rst_n || stop)
        begin
            cnt_reg <= '0;
            running <= 1'b0;
            done    <= 1'b0;
        end
        else if (load)
        begin
            cnt_reg <= count;
            running <= 1'b1;
            done    <= 1'b0;
        end
        else if (running)
        begin
            cnt_reg <= cnt_reg - 1'b1;
            done    <= (cnt_reg == {{(WIDTH-1){1'b0}}, 1'b1});
            running <= (cnt_reg != {{(WIDTH-1){1'b0}}, 1'b1});
        end
        else
        begin
            done <= 1'b0;
        end
    end
endmodule

// ### fes_top_assertions.sv
// port-level assertion checker for the flash erase sequencer
`timescale 1ns/1ps
`include "fes_map.svh"
module fes_checker
#(
    parameter int WINDOW_CYC = 20
)
(
    input wire logic                   clock,
    input wire logic                   rst_n,
    input wire logic                   write_strobe_n,
    input wire logic                   read_strobe_n,
    input wire logic [`FES_ADDR_W-1:0] addr,
    input wire logic [`FES_DATA_W-1:0] wdata,
    input wire logic [`FES_DATA_W-1:0] rdata,
    input wire logic                   rdata_valid,
    input wire logic                   erase_busy,
    input wire logic                   erase_timer_flag,
    input wire logic                   erase_suspended
);
    logic [15:0] gap_reg;
    logic [15:0] last_data_reg;
    logic        was_susp_reg;
    logic        chip_reg;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // saturates so a long quiet spell never wraps back to a small gap
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            gap_reg <= 16'hffff;
        else if ($rose(write_strobe_n))
            gap_reg <= 16'h0000;
        else if (gap_reg != 16'hffff)
            gap_reg <= gap_reg + 16'h0001;
    end
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            last_data_reg <= 16'h0000;
        else if ($rose(write_strobe_n))
            last_data_reg <= wdata;
    end
    // a resumed erase skips the window, so its flag rise is exempt
    always_ff @(posedge clock)
    begin
        if (!rst_n || !erase_busy)
            was_susp_reg <= 1'b0;
        else if (erase_suspended)
            was_susp_reg <= 1'b1;
    end
    always_ff @(posedge clock)
    begin
        if (!rst_n || !erase_busy)
            chip_reg <= 1'b0;
        else if ($rose(erase_busy) && last_data_reg == `FES_DAT_CHIP)
            chip_reg <= 1'b1;
    end
    sequence s_read_start;
        $fell(read_strobe_n);
    endsequence
    sequence s_answer;
        ##[3:5] rdata_valid;
    endsequence
    AST_READ_ANSWER: assert property (s_read_start |-> s_answer)
        else $error("read answer missing");
    AST_VALID_PULSE: assert property (rdata_valid |=> !rdata_valid)
        else $error("read valid longer than one cycle");
    AST_FLAG_BUSY: assert property (erase_timer_flag |-> erase_busy)
        else $error("timer flag without operation");
    AST_SUSP_BUSY: assert property (erase_suspended |-> erase_busy)
        else $error("suspended without operation");
    AST_WINDOW_MIN: assert property ($rose(erase_timer_flag)
        && last_data_reg == `FES_DAT_SECTOR && !was_susp_reg
        |-> gap_reg >= WINDOW_CYC)
        else $error("acceptance window closed early");
    AST_START_CAUSE: assert property ($rose(erase_busy)
        |-> gap_reg <= 16'd8)
        else $error("operation started without a write");
    AST_SUSP_CAUSE: assert property ($rose(erase_suspended)
        |-> gap_reg <= 16'd8)
        else $error("suspend without a write");
    AST_CHIP_NO_SUSP: assert property (chip_reg |-> !erase_suspended)
        else $error("chip erase was suspended");
    AST_RESET_STOPS: assert property (@(posedge clock) disable iff (1'b0)
        !rst_n |=> !erase_busy && !erase_timer_flag && !erase_suspended
        && !rdata_valid)
        else $error("reset did not stop operation");
endmodule
bind fes_top fes_checker #(.WINDOW_CYC(WINDOW_CYC)) chk
(
    .clock            (clock),
    .rst_n            (rst_n),
    .write_strobe_n   (write_strobe_n),
    .read_strobe_n    (read_strobe_n),
    .addr             (addr),
    .wdata            (wdata),
    .rdata            (rdata),
    .rdata_valid      (rdata_valid),
    .erase_busy       (erase_busy),
    .erase_timer_flag (erase_timer_flag),
    .erase_suspended  (erase_suspended)
);

// ### fes_host.sv
// host bus model issuing flash write and read cycles
`timescale 1ns/1ps
module fes_host
(
    input  wire logic        clock,
    input  wire logic [15:0] rdata,
    input  wire logic        rdata_valid,
    output logic             write_strobe_n,
    output logic             read_strobe_n,
    output logic      [11:0] addr,
    output logic      [15:0] wdata
);
    initial
    begin
        write_strobe_n = 1'b1;
        read_strobe_n  = 1'b1;
        addr           = 12'h000;
        wdata          = 16'h0000;
    end
    // nine cycles a write keeps queued sector writes inside the gap
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(negedge clock);
        addr           = a;
        wdata          = d;
        write_strobe_n = 1'b0;
        repeat (4) @(negedge clock);
        write_strobe_n = 1'b1;
        repeat (4) @(negedge clock);
        // released lines carry no meaning, so show the inverse
        addr  = ~a;
        wdata = ~d;
    endtask
    // strobe held for the whole answer window, data taken on the pulse
    task automatic rd(input logic [11:0] a, output logic [15:0] d);
        @(negedge clock);
        addr          = a;
        read_strobe_n = 1'b0;
        d             = 16'hxxxx;
        repeat (8)
        begin
            @(negedge clock);
            if (rdata_valid === 1'b1)
                d = rdata;
        end
        read_strobe_n = 1'b1;
        repeat (4) @(negedge clock);
        addr = ~a;
    endtask
endmodule

// ### fes_top_tb.sv
// self-checking bench for the flash erase sequencer
`timescale 1ns/1ps
`include "fes_map.svh"
module fes_top_tb;
    localparam logic [11:0] ROW_SECT [3] = '{12'h200, 12'h900, 12'h1a0};
    localparam logic [11:0] ROW_PROBE [3] = '{12'h2ab, 12'h9ff, 12'h300};
    localparam logic [15:0] ROW_EXP [3] = '{16'hffff, 16'hffff, 16'h5a5a};
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        write_strobe_n;
    logic        read_strobe_n;
    logic [11:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        rdata_valid;
    logic        erase_busy;
    logic        erase_timer_flag;
    logic        erase_suspended;
    logic [15:0] d;
    int          fails = 0;
    int          comparisons = 0;
    int          cycles = 0;
    // busy, flag, suspended packed so one compare covers all three
    wire  [15:0] lv = {13'h0, erase_busy, erase_timer_flag, erase_suspended};
    always #50 clock = ~clock;
    fes_top #(.WINDOW_CYC(20)) uut
    (
        .clock            (clock),
        .rst_n            (rst_n),
        .write_strobe_n   (write_strobe_n),
        .read_strobe_n    (read_strobe_n),
        .addr             (addr),
        .wdata            (wdata),
        .rdata            (rdata),
        .rdata_valid      (rdata_valid),
        .erase_busy       (erase_busy),
        .erase_timer_flag (erase_timer_flag),
        .erase_suspended  (erase_suspended)
    );
    fes_host host
    (
        .clock          (clock),
        .rdata          (rdata),
        .rdata_valid    (rdata_valid),
        .write_strobe_n (write_strobe_n),
        .read_strobe_n  (read_strobe_n),
        .addr           (addr),
        .wdata          (wdata)
    );
    task automatic chk(input string n, input logic [15:0] seen, exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic give_verdict;
        if (fails == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic erase_cmd(input logic [11:0] a, input logic [15:0] d6, d5);
        host.wr(`FES_UNLOCK_A1, `FES_DAT_AA);
        host.wr(`FES_UNLOCK_A2, `FES_DAT_55);
        host.wr(`FES_UNLOCK_A1, `FES_DAT_SETUP);
        host.wr(`FES_UNLOCK_A1, `FES_DAT_AA);
        host.wr(`FES_UNLOCK_A2, d5);
        host.wr(a, d6);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [15:0] e);
        host.rd(a, d);
        chk("rdata", d, e);
    endtask
    task automatic wait_idle;
        repeat (3000)
            if (erase_busy !== 1'b0)
                @(negedge clock);
    endtask
    task automatic wait_flag;
        repeat (300)
            if (erase_timer_flag !== 1'b1)
                @(negedge clock);
    endtask
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            fails++;
            give_verdict();
        end
    end
    initial
    begin
        repeat (12) @(negedge clock);
        chk("levels", lv, 16'h0000);
        rst_n = 1'b1;
        repeat (3) @(negedge clock);
        for (int i = 0; i < 3; i++)
        begin
            erase_cmd(ROW_SECT[i], `FES_DAT_SECTOR, `FES_DAT_55);
            wait_idle();
            rchk(ROW_PROBE[i], ROW_EXP[i]);
        end
        erase_cmd(12'h400, `FES_DAT_SECTOR, `FES_DAT_55);
        host.wr(12'h7f0, `FES_DAT_SECTOR);
        host.wr(12'h500, `FES_DAT_SECTOR);
        chk("levels", lv, 16'h0004);
        wait_flag();
        host.wr(12'h800, `FES_DAT_SECTOR); // outcome never relied on
        host.wr(`FES_UNLOCK_A1, 16'h00f0);
        chk("levels", lv, 16'h0006);
        host.rd(12'h450, d);
        chk("status", d & 16'h0088, 16'h0008);
        rchk(12'h000, 16'h5a5a);
        wait_idle();
        rchk(12'h7f0, 16'hffff);
        rchk(12'h500, 16'hffff);
        rchk(12'h600, 16'h5a5a);
        // a stray command inside the window must drop the whole erase
        erase_cmd(12'hd00, `FES_DAT_SECTOR, `FES_DAT_55);
        host.wr(`FES_UNLOCK_A1, 16'h00f0);
        repeat (4) @(negedge clock);
        chk("levels", lv, 16'h0000);
        rchk(12'hd00, 16'h5a5a);
        erase_cmd(12'he00, `FES_DAT_SECTOR, 16'h0056);
        repeat (4) @(negedge clock);
        chk("levels", lv, 16'h0000);
        rchk(12'he00, 16'h5a5a);
        erase_cmd(12'hb00, `FES_DAT_SECTOR, `FES_DAT_55);
        host.wr(12'hb00, `FES_DAT_SUSPEND);
        repeat (2) @(negedge clock);
        chk("levels", lv, 16'h0005);
        host.wr(12'hb00, `FES_DAT_RESUME);
        repeat (2) @(negedge clock);
        chk("levels", lv & 16'h0005, 16'h0004);
        host.wr(12'hb00, `FES_DAT_SUSPEND);
        chk("levels", lv, 16'h0005);
        host.wr(12'hb00, `FES_DAT_RESUME);
        wait_idle();
        rchk(12'hb40, 16'hffff);
        erase_cmd(`FES_UNLOCK_A1, `FES_DAT_CHIP, `FES_DAT_55);
        host.wr(12'h000, `FES_DAT_SUSPEND);
        host.wr(12'h300, `FES_DAT_SECTOR);
        chk("levels", lv & 16'h0005, 16'h0004);
        wait_idle();
        rchk(12'h300, 16'hffff);
        rchk(12'he00, 16'hffff);
        // reset in mid-erase must stop it without waiting for the passes
        erase_cmd(12'ha00, `FES_DAT_SECTOR, `FES_DAT_55);
        wait_flag();
        rst_n = 1'b0;
        repeat (2) @(negedge clock);
        chk("levels", lv, 16'h0000);
        rst_n = 1'b1;
        repeat (3) @(negedge clock);
        chk("levels", lv, 16'h0000);
        give_verdict();
    end
endmodule
